// *** rtl/fpx_pkg.sv ***
/*
  Shared constants, types and helpers of the floating subtract, square root and feature-mask unit.
  Assumes register-file operands in 64-bit register layout: sign, 11-bit exponent, 52-bit fraction.
*/
package fpx_pkg;
  localparam int MW = 57;
  localparam int ROOT_W = 55;
  localparam int RAD_W = 110;
  localparam int RAD_PAD = 56;
  localparam int CNT_W = 6;
  localparam int FW = 52;
  localparam int LSB_D = 3;
  localparam int LSB_S = 32;
  localparam int SGL_LOW = 29;
  localparam int FRAC_QUIET = 51;
  localparam int LIT_W = 8;
  localparam int DEST_W = 5;
  localparam logic [10:0] EXP_ONES = 11'h7ff;
  localparam logic [10:0] EXP_ONE = 11'h001;
  localparam logic signed [12:0] BIAS = 13'sh03ff;
  localparam logic signed [12:0] EMIN_D = 13'sh0001;
  localparam logic signed [12:0] EMAX_D = 13'sh07fe;
  localparam logic signed [12:0] EMIN_S = 13'sh0381;
  localparam logic signed [12:0] EMAX_S = 13'sh047e;
  localparam logic signed [12:0] EMIN_G = 13'sh0001;
  localparam logic signed [12:0] EMAX_G = 13'sh07ff;
  localparam logic signed [12:0] EMIN_F = 13'sh0381;
  localparam logic signed [12:0] EMAX_F = 13'sh047f;
  localparam logic [MW-1:0] UNIT_D = 57'h0_0000_0000_0008;
  localparam logic [MW-1:0] UNIT_S = 57'h0_0001_0000_0000;
  localparam logic [MW-1:0] KEEP_D = 57'h1ff_ffff_ffff_fff8;
  localparam logic [MW-1:0] KEEP_S = 57'h1ff_ffff_0000_0000;
  localparam logic [FW-1:0] FRAC_MAX_D = 52'hf_ffff_ffff_ffff;
  localparam logic [FW-1:0] FRAC_MAX_S = 52'hf_ffff_e000_0000;
  localparam logic [63:0] QNAN_DEFAULT = 64'h7ff8_0000_0000_0000;
  localparam logic [63:0] NEG_ZERO = 64'h8000_0000_0000_0000;
  // Bit 1: square root executes in hardware
  localparam logic [63:0] IMPL_FEATURES = 64'h0000_0000_0000_0002;

  typedef enum logic [2:0] {
    OP_SQRT_IEEE_SINGLE = 3'h0,
    OP_SQRT_IEEE_DOUBLE = 3'h1,
    OP_SUB_LEGACY_SINGLE = 3'h2,
    OP_SUB_LEGACY_DOUBLE = 3'h3,
    OP_SUB_IEEE_SINGLE = 3'h4,
    OP_SUB_IEEE_DOUBLE = 3'h5,
    OP_FEATURE_MASK_QUERY = 3'h6
  } fpx_op_e;
  typedef enum logic [1:0] {RQ_NORMAL = 2'h0, RQ_CHOPPED = 2'h1, RQ_MINUS_INF = 2'h2, RQ_DYNAMIC = 2'h3} fpx_rq_e;
  typedef enum logic [1:0] {RM_CHOP = 2'h0, RM_MINUS = 2'h1, RM_NEAREST = 2'h2, RM_PLUS = 2'h3} fpx_rm_e;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_ROOT = 4'h2, ST_NORM = 4'h4, ST_ROUND = 4'h8} fpx_state_e;

  typedef struct packed {
    logic valid;
    fpx_op_e op;
    fpx_rq_e rq;
    logic trap_inexact;
    logic trap_underflow;
    logic trap_complete;
    logic use_literal;
    logic [LIT_W-1:0] literal;
    logic [DEST_W-1:0] dest;
    logic [63:0] fp_source_one;
    logic [63:0] fp_source_two;
    logic [63:0] int_source_two;
  } fpx_req_s;

  typedef struct packed {
    logic valid;
    fpx_op_e op;
    logic [DEST_W-1:0] dest;
    logic to_int;
    logic [63:0] result;
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
    logic illegal;
    logic trap;
    logic sw_complete;
  } fpx_resp_s;

  function automatic logic fpx_is_sqrt(fpx_op_e op);
    return op == OP_SQRT_IEEE_SINGLE || op == OP_SQRT_IEEE_DOUBLE;
  endfunction
  function automatic logic fpx_is_legacy(fpx_op_e op);
    return op == OP_SUB_LEGACY_SINGLE || op == OP_SUB_LEGACY_DOUBLE;
  endfunction
  function automatic logic fpx_is_single(fpx_op_e op);
    return op == OP_SQRT_IEEE_SINGLE || op == OP_SUB_LEGACY_SINGLE || op == OP_SUB_IEEE_SINGLE;
  endfunction
endpackage

// *** rtl/fpx_root.sv ***
/*
  Iterative integer square root, one result bit per clock.
  Assumes start is only raised while no root is in progress.
*/
`timescale 1ns/10ps
module fpx_root (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [fpx_pkg::RAD_W-1:0] radicand,
  output logic done,
  output logic [fpx_pkg::ROOT_W-1:0] root,
  output logic rem_nz
);
  import fpx_pkg::*;
  logic [RAD_W-1:0] rad_reg, rad_next;
  logic [ROOT_W+1:0] rem_reg, rem_next, rem_t, trial;
  logic [ROOT_W-1:0] root_reg, root_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, done_reg, done_next;

  assign rem_t = {rem_reg[ROOT_W-1:0], rad_reg[RAD_W-1 -: 2]};
  assign trial = {root_reg, 2'h1};

  always_comb begin
    rad_next = rad_reg;
    rem_next = rem_reg;
    root_next = root_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      rad_next = radicand;
      rem_next = '0;
      root_next = '0;
      cnt_next = CNT_W'(ROOT_W);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      rad_next = rad_reg << 2;
      if (rem_t >= trial) begin
        rem_next = rem_t - trial;
        root_next = {root_reg[ROOT_W-2:0], 1'b1};
      end else begin
        rem_next = rem_t;
        root_next = {root_reg[ROOT_W-2:0], 1'b0};
      end
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rad_reg <= '0;
      rem_reg <= '0;
      root_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rad_reg <= rad_next;
      rem_reg <= rem_next;
      root_reg <= root_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
  assign root = root_reg;
  assign rem_nz = rem_reg != '0;
endmodule

// *** rtl/fpx_unit.sv ***
/*
  Execute unit for IEEE square root, legacy and IEEE subtract, and the feature-mask query.
  Assumes issue logic holds a request until ready and encodes the zero registers where required.
*/
`timescale 1ns/10ps
// Contract
// - Square root of source two, rounded
// - Negative operand invalid, minus zero passes
// - No overflow or underflow; underflow qualifier ignored
// - Only inexact and invalid; listed qualifiers accepted
// - Canonical single in, canonical single out
// - Destination gets source one minus source two
// - Legacy: round first, then range check
// - Legacy dirty zero or reserved operand traps
// - Legacy: no inexact, chopped rounding qualifier only
// - IEEE subtract adds inexact, all qualifiers
// - IEEE: round first, then range check
// - Query clears bits of present extensions
// - Low eight bits hold standard extensions
// - Hardware square root clears bit one
module fpx_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire fpx_pkg::fpx_req_s req,
  input wire fpx_pkg::fpx_rm_e dyn_round,
  output logic ready,
  output fpx_pkg::fpx_resp_s resp
);
  import fpx_pkg::*;
  fpx_state_e state_reg, state_next;
  fpx_op_e op_reg, op_next;
  fpx_rm_e rm_reg, rm_next, rm_in;
  logic ti_reg, ti_next, tu_reg, tu_next, ts_reg, ts_next;
  logic [DEST_W-1:0] dest_reg, dest_next;
  logic sign_reg, sign_next;
  logic signed [12:0] exp_reg, exp_next;
  logic [MW-1:0] mant_reg, mant_next;
  fpx_resp_s resp_reg, resp_next;
  logic ready_reg, ready_next;
  logic root_start, root_done, root_rem_nz;
  logic [ROOT_W-1:0] root_val;
  logic accept, sa, sb, a_ge, eff_add, leg_bad, sticky;
  logic [10:0] ea, eb, ea_e, eb_e, diff;
  logic [FW-1:0] fa, fb;
  logic a_zero, b_zero, a_nan, b_nan, a_snan, b_snan, a_inf, b_inf, a_dirty, b_dirty;
  logic [MW-1:0] ma, mb, big, lesser, sm_j, sum;
  logic signed [12:0] u, sq_exp, rexp, emin, emax;
  logic [53:0] rad_top;
  logic [63:0] fmask_src;
  logic sgl, leg, g, st, lb, inx, inc, carry, to_inf;
  logic [MW-1:0] rnd;
  logic [FW-1:0] rfrac;

  assign accept = req.valid && state_reg == ST_IDLE;
  assign {sa, ea, fa} = req.fp_source_one;
  assign {sb, eb, fb} = req.fp_source_two;
  assign a_zero = ea == '0 && fa == '0;
  assign b_zero = eb == '0 && fb == '0;
  assign a_nan = ea == EXP_ONES && fa != '0;
  assign b_nan = eb == EXP_ONES && fb != '0;
  assign a_snan = a_nan && !fa[FRAC_QUIET];
  assign b_snan = b_nan && !fb[FRAC_QUIET];
  assign a_inf = ea == EXP_ONES && fa == '0;
  assign b_inf = eb == EXP_ONES && fb == '0;
  // A set sign with zero exponent is a reserved operand, not a true zero
  assign a_dirty = ea == '0 && (fa != '0 || sa);
  assign b_dirty = eb == '0 && (fb != '0 || sb);
  assign ea_e = (ea == '0) ? EXP_ONE : ea;
  assign eb_e = (eb == '0) ? EXP_ONE : eb;
  assign ma = {1'b0, ea != '0, fa, 3'h0};
  assign mb = {1'b0, eb != '0, fb, 3'h0};
  // Align, then subtract source two from one
  assign a_ge = {ea, fa} >= {eb, fb};
  assign diff = a_ge ? ea_e - eb_e : eb_e - ea_e;
  assign big = a_ge ? ma : mb;
  assign lesser = a_ge ? mb : ma;
  assign sticky = |(lesser & ~({MW{1'b1}} << diff));
  // Shifted-out bits jammed into the lsb so cancellation keeps inexactness
  assign sm_j = (lesser >> diff) | {{(MW-1){1'b0}}, sticky};
  assign eff_add = sa != sb;
  assign sum = eff_add ? big + sm_j : big - sm_j;
  // Even exponent, radicand from source two
  assign u = $signed({2'h0, eb_e}) - BIAS;
  assign sq_exp = (u >>> 1) + BIAS;
  assign rad_top = u[0] ? {eb != '0, fb, 1'b0} : {1'b0, eb != '0, fb};
  assign fmask_src = req.use_literal ? {{(64-LIT_W){1'b0}}, req.literal} : req.int_source_two;
  assign leg_bad = req.rq == RQ_MINUS_INF || req.rq == RQ_DYNAMIC || req.trap_inexact;

  always_comb begin
    case (req.rq)
      RQ_NORMAL: rm_in = RM_NEAREST;
      RQ_CHOPPED: rm_in = RM_CHOP;
      RQ_MINUS_INF: rm_in = RM_MINUS;
      default: rm_in = dyn_round;
    endcase
  end

  // Rounding stage operates on the held normalised value
  assign sgl = fpx_is_single(op_reg);
  assign leg = fpx_is_legacy(op_reg);
  assign g = sgl ? mant_reg[LSB_S-1] : mant_reg[LSB_D-1];
  assign st = sgl ? |mant_reg[LSB_S-2:0] : |mant_reg[LSB_D-2:0];
  assign lb = sgl ? mant_reg[LSB_S] : mant_reg[LSB_D];
  assign inx = g | st;
  always_comb begin
    case (rm_reg)
      RM_NEAREST: inc = g && (st || lb);
      RM_MINUS: inc = sign_reg && inx;
      RM_PLUS: inc = !sign_reg && inx;
      default: inc = 1'b0;
    endcase
  end
  // Single rounds at its own lsb, low bits cleared
  assign rnd = (mant_reg & (sgl ? KEEP_S : KEEP_D)) + (inc ? (sgl ? UNIT_S : UNIT_D) : '0);
  assign carry = rnd[MW-1];
  assign rexp = exp_reg + $signed({12'h000, carry});
  assign rfrac = carry ? '0 : rnd[LSB_D +: FW];
  assign emin = leg ? (sgl ? EMIN_F : EMIN_G) : (sgl ? EMIN_S : EMIN_D);
  assign emax = leg ? (sgl ? EMAX_F : EMAX_G) : (sgl ? EMAX_S : EMAX_D);
  assign to_inf = rm_reg == RM_NEAREST || (rm_reg == RM_PLUS && !sign_reg) || (rm_reg == RM_MINUS && sign_reg);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    rm_next = rm_reg;
    ti_next = ti_reg;
    tu_next = tu_reg;
    ts_next = ts_reg;
    dest_next = dest_reg;
    sign_next = sign_reg;
    exp_next = exp_reg;
    mant_next = mant_reg;
    resp_next = resp_reg;
    resp_next.valid = 1'b0;
    root_start = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          op_next = req.op;
          rm_next = rm_in;
          ti_next = req.trap_inexact;
          // Underflow qualifier ignored for square root
          tu_next = req.trap_underflow && !fpx_is_sqrt(req.op);
          ts_next = req.trap_complete;
          dest_next = req.dest;
          resp_next = '0;
          resp_next.op = req.op;
          resp_next.dest = req.dest;
          resp_next.sw_complete = req.trap_complete;
          resp_next.valid = 1'b1;
          case (req.op)
            OP_FEATURE_MASK_QUERY: begin
              resp_next.result = fmask_src & ~IMPL_FEATURES;
              resp_next.to_int = 1'b1;
            end
            OP_SQRT_IEEE_SINGLE, OP_SQRT_IEEE_DOUBLE: begin
              if (b_snan || (sb && !b_zero && !b_nan)) begin
                resp_next.invalid = 1'b1;
                resp_next.result = QNAN_DEFAULT;
              end else if (b_nan) begin
                resp_next.result = req.fp_source_two | {12'h000, 1'b1, 51'h0};
              end else if (b_zero || b_inf) begin
                resp_next.result = req.fp_source_two;
              end else begin
                resp_next.valid = 1'b0;
                root_start = 1'b1;
                sign_next = 1'b0;
                exp_next = sq_exp;
                state_next = ST_ROOT;
              end
            end
            default: begin
              if (fpx_is_legacy(req.op) && leg_bad) begin
                // Only chopped, completion and underflow qualifiers
                resp_next.illegal = 1'b1;
              end else if (fpx_is_legacy(req.op) && (a_dirty || b_dirty)) begin
                // Reserved operand or dirty zero traps
                resp_next.invalid = 1'b1;
              end else if (!fpx_is_legacy(req.op) && (a_snan || b_snan || (a_inf && b_inf && !eff_add))) begin
                resp_next.invalid = 1'b1;
                resp_next.result = QNAN_DEFAULT;
              end else if (!fpx_is_legacy(req.op) && (a_nan || b_nan)) begin
                resp_next.result = (a_nan ? req.fp_source_one : req.fp_source_two) | {12'h000, 1'b1, 51'h0};
              end else if (!fpx_is_legacy(req.op) && a_inf) begin
                resp_next.result = req.fp_source_one;
              end else if (!fpx_is_legacy(req.op) && b_inf) begin
                resp_next.result = {!sb, req.fp_source_two[62:0]};
              end else begin
                // Exact cancellation gives minus zero only toward minus
                resp_next.valid = 1'b0;
                sign_next = (!eff_add && sum == '0) ? rm_in == RM_MINUS : (a_ge ? sa : !sb);
                exp_next = $signed({2'h0, a_ge ? ea_e : eb_e});
                mant_next = sum;
                state_next = ST_NORM;
              end
            end
          endcase
          if (fpx_is_single(req.op)) begin
            resp_next.result[SGL_LOW-1:0] = '0;
          end
        end
      end
      ST_ROOT: begin
        if (root_done) begin
          mant_next = {1'b0, root_val, root_rem_nz};
          state_next = ST_NORM;
        end
      end
      ST_NORM: begin
        if (mant_reg[MW-1]) begin
          mant_next = {1'b0, mant_reg[MW-1:2], mant_reg[1] | mant_reg[0]};
          exp_next = exp_reg + 13'sh0001;
          state_next = ST_ROUND;
        end else if (mant_reg == '0 || mant_reg[MW-2]) begin
          state_next = ST_ROUND;
        end else begin
          mant_next = mant_reg << 1;
          exp_next = exp_reg - 13'sh0001;
        end
      end
      ST_ROUND: begin
        resp_next = '0;
        resp_next.valid = 1'b1;
        resp_next.op = op_reg;
        resp_next.dest = dest_reg;
        resp_next.sw_complete = ts_reg;
        state_next = ST_IDLE;
        if (mant_reg == '0) begin
          resp_next.result = {sign_reg, 63'h0};
        end else if (rexp > emax) begin
          resp_next.overflow = 1'b1;
          resp_next.inexact = !leg;
          if (!leg) begin
            resp_next.result = to_inf ? {sign_reg, EXP_ONES, {FW{1'b0}}} :
              {sign_reg, emax[10:0], sgl ? FRAC_MAX_S : FRAC_MAX_D};
          end
        end else if (rexp < emin) begin
          resp_next.underflow = 1'b1;
          resp_next.inexact = !leg;
          resp_next.result = {sign_reg && !leg, 63'h0};
        end else begin
          resp_next.inexact = inx && !leg;
          resp_next.result = {sign_reg, rexp[10:0], rfrac};
        end
      end
      default: state_next = ST_IDLE;
    endcase
    resp_next.trap = resp_next.valid && (resp_next.invalid || resp_next.overflow || resp_next.illegal ||
      (resp_next.underflow && tu_next) || (resp_next.inexact && ti_next));
    ready_next = state_next == ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_SQRT_IEEE_SINGLE;
      rm_reg <= RM_CHOP;
      ti_reg <= 1'b0;
      tu_reg <= 1'b0;
      ts_reg <= 1'b0;
      dest_reg <= '0;
      sign_reg <= 1'b0;
      exp_reg <= '0;
      mant_reg <= '0;
      resp_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      rm_reg <= rm_next;
      ti_reg <= ti_next;
      tu_reg <= tu_next;
      ts_reg <= ts_next;
      dest_reg <= dest_next;
      sign_reg <= sign_next;
      exp_reg <= exp_next;
      mant_reg <= mant_next;
      resp_reg <= resp_next;
      ready_reg <= ready_next;
    end
  end

  fpx_root u_root (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(root_start),
    .radicand({rad_top, {RAD_PAD{1'b0}}}),
    .done(root_done),
    .root(root_val),
    .rem_nz(root_rem_nz)
  );

  assign ready = ready_reg;
  assign resp = resp_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sub_taken;
    accept && !fpx_is_sqrt(req.op) && req.op != OP_FEATURE_MASK_QUERY;
  endsequence
  sequence s_root_taken;
    root_start;
  endsequence
  a_fmask_clear: assert property (accept && req.op == OP_FEATURE_MASK_QUERY |=>
    resp_reg.valid && resp_reg.to_int && resp_reg.result == ($past(fmask_src) & ~IMPL_FEATURES))
    else $error("feature mask result wrong");
  a_fmask_bit1: assert property (resp_reg.valid && resp_reg.to_int |-> !resp_reg.result[1])
    else $error("feature bit one not cleared");
  a_neg_zero: assert property (accept && fpx_is_sqrt(req.op) && req.fp_source_two == NEG_ZERO |=>
    resp_reg.valid && resp_reg.result == NEG_ZERO && !resp_reg.invalid)
    else $error("root of minus zero wrong");
  a_sqrt_negative: assert property (accept && fpx_is_sqrt(req.op) && sb && !b_zero && !b_nan |=>
    resp_reg.valid && resp_reg.invalid && resp_reg.trap)
    else $error("negative root not invalid");
  a_sqrt_range: assert property (resp_reg.valid && fpx_is_sqrt(resp_reg.op) |->
    !resp_reg.overflow && !resp_reg.underflow && !resp_reg.illegal)
    else $error("root raised range exception");
  a_single_canon: assert property (resp_reg.valid && fpx_is_single(resp_reg.op) |->
    resp_reg.result[SGL_LOW-1:0] == '0)
    else $error("single result not canonical");
  a_legacy_dirty: assert property (accept && fpx_is_legacy(req.op) && !leg_bad && (a_dirty || b_dirty) |=>
    resp_reg.valid && resp_reg.invalid && resp_reg.trap)
    else $error("dirty operand not trapped");
  a_legacy_flags: assert property (resp_reg.valid && fpx_is_legacy(resp_reg.op) |-> !resp_reg.inexact)
    else $error("legacy raised inexact");
  a_sub_latency: assert property (s_sub_taken |-> ##[1:70] resp_reg.valid)
    else $error("subtract answer late");
  a_root_latency: assert property (s_root_taken |=> (!ready_reg)[*8] ##[1:80] resp_reg.valid)
    else $error("root answer timing wrong");
endmodule

// *** verification/fpx_issuer.sv ***
/*
  Issue-side model: presents one request and holds it until the unit takes it.
  Assumes ready comes from a register and is sampled at the rising edge.
*/
`timescale 1ns/10ps
module fpx_issuer (
  input wire logic core_clk,
  input wire logic ready,
  output fpx_pkg::fpx_req_s req
);
  import fpx_pkg::*;
  initial req = '0;
  task automatic issue(input fpx_req_s r);
    fpx_req_s idle_r;
    @(posedge core_clk);
    #1;
    if (r.op inside {OP_SQRT_IEEE_SINGLE, OP_SQRT_IEEE_DOUBLE}) r.fp_source_one = 64'h0;
    // Square root source one has no port, zero register assumed
    r.valid = 1'b1;
    req = r;
    do @(posedge core_clk); while (ready !== 1'b1);
    #1;
    // Released fields flip so stale values cannot pass for held ones
    idle_r = ~r;
    idle_r.valid = 1'b0;
    req = idle_r;
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  Self-checking bench for the subtract, square root and feature-mask unit.
  Assumes the issuer model in fpx_issuer.sv and the package constants.
*/
`timescale 1ns/10ps
module testbench;
  import fpx_pkg::*;
  logic core_clk;
  logic reset_n;
  fpx_rm_e dyn_round;
  fpx_req_s req;
  logic ready;
  fpx_resp_s resp;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  fpx_unit fpx_unit_inst (.core_clk(core_clk), .reset_n(reset_n), .req(req), .dyn_round(dyn_round),
    .ready(ready), .resp(resp));
  fpx_issuer fpx_issuer_inst (.core_clk(core_clk), .ready(ready), .req(req));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] expected);
    compares++;
    if (seen !== expected) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  function automatic fpx_req_s mk(fpx_op_e op, fpx_rq_e rq, logic [63:0] a, logic [63:0] b);
    fpx_req_s r;
    r = '0;
    r.op = op;
    r.rq = rq;
    r.fp_source_one = a;
    r.fp_source_two = b;
    return r;
  endfunction
  // Flags: invalid, overflow, underflow, inexact, illegal, trap
  task automatic exec(input fpx_req_s r, input logic [63:0] res, input logic [5:0] flags);
    int n;
    fpx_issuer_inst.issue(r);
    n = 0;
    // Immediate answers already stand when the issuer returns
    while (resp.valid !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({63'h0, resp.valid}, 64'h1);
    check(resp.result, res);
    check({58'h0, resp.invalid, resp.overflow, resp.underflow, resp.inexact, resp.illegal, resp.trap},
      {58'h0, flags});
    check({55'h0, resp.op, resp.dest, resp.sw_complete}, {55'h0, r.op, r.dest, r.trap_complete});
  endtask
  task automatic t_query();
    fpx_req_s r;
    r = mk(OP_FEATURE_MASK_QUERY, RQ_NORMAL, 64'h0, 64'h0);
    r.int_source_two = 64'hffff_ffff_ffff_ffff;
    exec(r, 64'hffff_ffff_ffff_fffd, 6'h00);
    check({63'h0, resp.to_int}, 64'h1);
    r.use_literal = 1'b1;
    r.literal = 8'hff;
    exec(r, 64'h0000_0000_0000_00fd, 6'h00);
    r.literal = 8'h02;
    exec(r, 64'h0, 6'h00);
    @(posedge core_clk);
    #1;
    reset_n = 1'b0;
    @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    r.literal = 8'h03;
    exec(r, 64'h1, 6'h00);
  endtask
  task automatic t_sqrt();
    fpx_req_s r;
    exec(mk(OP_SQRT_IEEE_DOUBLE, RQ_NORMAL, 64'h4008_0000_0000_0000, 64'h4010_0000_0000_0000),
      64'h4000_0000_0000_0000, 6'h00);
    r = mk(OP_SQRT_IEEE_DOUBLE, RQ_NORMAL, 64'h0, 64'h4000_0000_0000_0000);
    r.trap_underflow = 1'b1;
    r.dest = 5'h15;
    r.trap_complete = 1'b1;
    exec(r, 64'h3ff6_a09e_667f_3bcd, 6'h04);
    r.rq = RQ_CHOPPED;
    r.trap_inexact = 1'b1;
    exec(r, 64'h3ff6_a09e_667f_3bcc, 6'h05);
    r.rq = RQ_MINUS_INF;
    exec(r, 64'h3ff6_a09e_667f_3bcc, 6'h05);
    dyn_round = RM_PLUS;
    r.rq = RQ_DYNAMIC;
    exec(r, 64'h3ff6_a09e_667f_3bcd, 6'h05);
    dyn_round = RM_NEAREST;
    exec(mk(OP_SQRT_IEEE_SINGLE, RQ_NORMAL, 64'h0, 64'h4000_0000_0000_0000),
      64'h3ff6_a09e_6000_0000, 6'h04);
  endtask
  task automatic t_sqrt_sign();
    exec(mk(OP_SQRT_IEEE_DOUBLE, RQ_NORMAL, 64'h0, 64'hc010_0000_0000_0000), QNAN_DEFAULT, 6'h21);
    exec(mk(OP_SQRT_IEEE_SINGLE, RQ_NORMAL, 64'h0, NEG_ZERO), NEG_ZERO, 6'h00);
  endtask
  task automatic t_sub_ieee();
    fpx_req_s r;
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_NORMAL, 64'h7fef_ffff_ffff_ffff, 64'hffef_ffff_ffff_ffff),
      64'h7ff0_0000_0000_0000, 6'h15);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_CHOPPED, 64'h7fef_ffff_ffff_ffff, 64'hffef_ffff_ffff_ffff),
      64'h7fef_ffff_ffff_ffff, 6'h15);
    r = mk(OP_SUB_IEEE_DOUBLE, RQ_NORMAL, 64'h0018_0000_0000_0000, 64'h0010_0000_0000_0000);
    r.trap_underflow = 1'b1;
    exec(r, 64'h0, 6'h0d);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_NORMAL, 64'h7ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000),
      QNAN_DEFAULT, 6'h21);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_NORMAL, 64'h3ff0_0000_0000_0000, 64'h4008_0000_0000_0000),
      64'hc000_0000_0000_0000, 6'h00);
    exec(mk(OP_SUB_IEEE_SINGLE, RQ_NORMAL, 64'h4008_0000_0000_0000, 64'h3ff0_0000_0000_0000),
      64'h4000_0000_0000_0000, 6'h00);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_NORMAL, 64'h3ff0_0000_0000_0000, 64'h3c30_0000_0000_0000),
      64'h3ff0_0000_0000_0000, 6'h04);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_CHOPPED, 64'h3ff0_0000_0000_0000, 64'h3c30_0000_0000_0000),
      64'h3fef_ffff_ffff_ffff, 6'h04);
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_MINUS_INF, 64'h3ff0_0000_0000_0000, 64'h3c30_0000_0000_0000),
      64'h3fef_ffff_ffff_ffff, 6'h04);
    dyn_round = RM_PLUS;
    exec(mk(OP_SUB_IEEE_DOUBLE, RQ_DYNAMIC, 64'h3ff0_0000_0000_0000, 64'h3c30_0000_0000_0000),
      64'h3ff0_0000_0000_0000, 6'h04);
    dyn_round = RM_NEAREST;
  endtask
  task automatic t_sub_legacy();
    exec(mk(OP_SUB_LEGACY_DOUBLE, RQ_NORMAL, 64'h4008_0000_0000_0000, 64'h3ff0_0000_0000_0000),
      64'h4000_0000_0000_0000, 6'h00);
    exec(mk(OP_SUB_LEGACY_SINGLE, RQ_CHOPPED, 64'h3ff0_0000_0000_0000, 64'h3c30_0000_0000_0000),
      64'h3fef_ffff_e000_0000, 6'h00);
    exec(mk(OP_SUB_LEGACY_DOUBLE, RQ_NORMAL, 64'h3ff0_0000_0000_0000, 64'h0000_0000_0000_0001),
      64'h0, 6'h21);
    exec(mk(OP_SUB_LEGACY_DOUBLE, RQ_MINUS_INF, 64'h4008_0000_0000_0000, 64'h3ff0_0000_0000_0000),
      64'h0, 6'h03);
    exec(mk(OP_SUB_LEGACY_DOUBLE, RQ_NORMAL, 64'h7fff_ffff_ffff_ffff, 64'hffff_ffff_ffff_ffff),
      64'h0, 6'h11);
  endtask
  initial begin
    reset_n = 1'b0;
    dyn_round = RM_NEAREST;
    repeat (2) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_query();
    t_sqrt();
    t_sqrt_sign();
    t_sub_ieee();
    t_sub_legacy();
    tally_and_finish();
  end
  // Ceiling well above the longest expected run of about 500 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
endmodule
